//--- verilog/thgs_pkg.sv
`default_nettype none
package thgs_pkg;
    // ***********************************
    // timing
    // ***********************************
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned SIMUL_WINDOW_MS = 500;
    localparam int unsigned SIMUL_WINDOW_CYCLES = (CLK_HZ / 1000) * SIMUL_WINDOW_MS;
    localparam int unsigned N_PSTOP = 2;

    // ***********************************
    // reset values
    // ***********************************
    localparam logic RUN_RST = 1'b0;
    localparam logic LATCH_RST = 1'b1;

    // ***********************************
    // carriers
    // ***********************************
    typedef struct packed {
        logic left;
        logic right;
    } thgs_hands_t;

    typedef struct packed {
        logic run;
        logic stop_cmd;
        logic latched;
        logic window_expired;
        logic blocked;
    } thgs_status_t;

    typedef enum logic [3:0] {
        THGS_IDLE = 4'b0001,
        THGS_ARMED = 4'b0010,
        THGS_RUN = 4'b0100,
        THGS_BLOCK = 4'b1000
    } thgs_thc_state_t;
endpackage
`default_nettype wire

//--- verilog/thgs_sync.sv
`default_nettype none
module thgs_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("width must be at least one");
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            meta_reg <= '0;
            q_reg <= '0;
        end
        else
        begin
            meta_reg <= d_in;
            q_reg <= meta_reg;
        end
    end

    assign q_out = q_reg;
endmodule
`default_nettype wire

//--- verilog/thgs_top.sv
// What this block does
// - Accept two-hand start only if second hand follows first within 500 ms.
// - Expired window blocks initiation until both hands are released.
// - Run output stays active only while both hands stay actuated.
// - Releasing either hand drops the run output at once.
// - New cycle needs both hands released then actuated again.
// - Open guard holds hazard off; opening while running issues stop.
// - Guard closing alone never starts motion; fresh initiation needed.
// - Pass-through mode latches stop after any stop command.
// - In pass-through mode, latched stop clears only on dedicated reset input, not start.
// - Each protective stop input selects automatic or manual reset.
// - Protective stop deasserts the actuator power outputs.
`default_nettype none
module thgs_top #(
    parameter int unsigned N_PSTOP = thgs_pkg::N_PSTOP,
    parameter int unsigned WINDOW_CYCLES = thgs_pkg::SIMUL_WINDOW_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire thgs_pkg::thgs_hands_t hands_in,
    input wire logic guard_closed_in,
    input wire logic [N_PSTOP-1:0] pstop_ok_in,
    input wire logic [N_PSTOP-1:0] pstop_manual_in,
    input wire logic reset_switch_in,
    input wire logic pass_through_in,
    output logic [1:0] machine_stop_elements_out,
    output logic stop_cmd_out,
    output thgs_pkg::thgs_status_t status_out
);
    // ***********************************
    // checks and declarations
    // ***********************************
    if (N_PSTOP < 1 || WINDOW_CYCLES < 2)
    begin : g_bad_params
        $error("unsupported parameter values");
    end

    localparam int CW = $clog2(WINDOW_CYCLES + 1);
    localparam int SW = 2 * N_PSTOP + 5;

    logic [SW-1:0] raw_sync;
    logic [SW-1:0] pin_sync;
    logic left;
    logic right;
    logic guard_ok;
    logic rst_sw;
    logic pass_mode;
    logic [N_PSTOP-1:0] ps_ok;
    logic [N_PSTOP-1:0] ps_manual;
    logic rst_sw_d_reg;
    logic rst_rise;
    logic [1:0] settle_reg;
    logic settled;
    logic both;
    logic none;
    logic [CW-1:0] win_cnt_reg;
    thgs_pkg::thgs_thc_state_t state_reg;
    thgs_pkg::thgs_thc_state_t state_next;
    logic [N_PSTOP-1:0] ps_hold_reg;
    logic latch_reg;
    logic expired_reg;
    logic permit;
    logic run_reg;
    logic stop_reg;
    logic stop_event;

    // ***********************************
    // input synchronisers
    // ***********************************
    assign raw_sync = {pstop_manual_in, pstop_ok_in, pass_through_in, reset_switch_in,
        guard_closed_in, hands_in.right, hands_in.left};

    thgs_sync #(
        .WIDTH(SW)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .d_in(raw_sync),
        .q_out(pin_sync)
    );

    assign left = pin_sync[0];
    assign right = pin_sync[1];
    assign guard_ok = pin_sync[2];
    assign rst_sw = pin_sync[3];
    assign pass_mode = pin_sync[4];
    assign ps_ok = pin_sync[N_PSTOP+4:5];
    assign ps_manual = pin_sync[SW-1:N_PSTOP+5];
    assign both = left & right;
    assign none = !left && !right;

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_sw_d_reg <= 1'b0;
            settle_reg <= 2'h0;
        end
        else
        begin
            rst_sw_d_reg <= rst_sw;
            settle_reg <= {settle_reg[0], 1'b1};
        end
    end

    // synchronisers show reset zeros until settled
    assign settled = settle_reg[1];
    assign rst_rise = rst_sw & ~rst_sw_d_reg;

    // ***********************************
    // protective stop inputs
    // ***********************************
    // a stopped input holds until it clears, then auto or on reset switch
    generate
        for (genvar i = 0; i < N_PSTOP; i++)
        begin : g_pstop
            always_ff @(posedge sys_clk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                begin
                    ps_hold_reg[i] <= 1'b1;
                end
                else if (!ps_ok[i])
                begin
                    ps_hold_reg[i] <= 1'b1;
                end
                else if (!ps_manual[i] || rst_rise)
                begin
                    ps_hold_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ***********************************
    // stop event and latch
    // ***********************************
    assign stop_event = run_reg && (!guard_ok || !(&ps_ok));

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            latch_reg <= thgs_pkg::LATCH_RST;
        end
        else if (pass_mode && (!guard_ok || !(&ps_ok)))
        begin
            latch_reg <= 1'b1;
        end
        else if (rst_rise)
        begin
            latch_reg <= 1'b0;
        end
        else if (!pass_mode && settled)
        begin
            latch_reg <= 1'b0;
        end
    end

    assign permit = guard_ok && (&ps_ok) && !(|ps_hold_reg) && !latch_reg;

    // ***********************************
    // simultaneity window
    // ***********************************
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            win_cnt_reg <= '0;
        end
        else if (state_reg == thgs_pkg::THGS_ARMED)
        begin
            if (win_cnt_reg < CW'(WINDOW_CYCLES))
            begin
                win_cnt_reg <= win_cnt_reg + CW'(1);
            end
        end
        else
        begin
            win_cnt_reg <= '0;
        end
    end

    // ***********************************
    // two-hand initiation state machine
    // ***********************************
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            thgs_pkg::THGS_IDLE:
            begin
                if (both && permit)
                begin
                    state_next = thgs_pkg::THGS_RUN;
                end
                else if (!none)
                begin
                    state_next = thgs_pkg::THGS_ARMED;
                end
            end
            thgs_pkg::THGS_ARMED:
            begin
                if (none)
                begin
                    state_next = thgs_pkg::THGS_IDLE;
                end
                else if (win_cnt_reg >= CW'(WINDOW_CYCLES))
                begin
                    state_next = thgs_pkg::THGS_BLOCK;
                end
                else if (both)
                begin
                    state_next = permit ? thgs_pkg::THGS_RUN : thgs_pkg::THGS_BLOCK;
                end
            end
            thgs_pkg::THGS_RUN:
            begin
                if (!both || !permit)
                begin
                    state_next = thgs_pkg::THGS_BLOCK;
                end
            end
            thgs_pkg::THGS_BLOCK:
            begin
                if (none && settled)
                begin
                    state_next = thgs_pkg::THGS_IDLE;
                end
            end
            default:
            begin
                state_next = thgs_pkg::THGS_BLOCK;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_reg <= thgs_pkg::THGS_BLOCK;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            expired_reg <= 1'b0;
        end
        else if (state_reg == thgs_pkg::THGS_ARMED && win_cnt_reg >= CW'(WINDOW_CYCLES))
        begin
            expired_reg <= 1'b1;
        end
        else if (none)
        begin
            expired_reg <= 1'b0;
        end
    end

    // ***********************************
    // outputs
    // ***********************************
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            run_reg <= thgs_pkg::RUN_RST;
            stop_reg <= 1'b0;
        end
        else
        begin
            run_reg <= (state_next == thgs_pkg::THGS_RUN);
            stop_reg <= stop_event;
        end
    end

    assign machine_stop_elements_out = {run_reg, run_reg};
    assign stop_cmd_out = stop_reg;
    assign status_out = '{run: run_reg, stop_cmd: stop_reg, latched: latch_reg,
        window_expired: expired_reg, blocked: (state_reg == thgs_pkg::THGS_BLOCK)};
endmodule
`default_nettype wire

//--- sim/thgs_assertions.sv
`default_nettype none
module thgs_assertions #(
    parameter int unsigned N_PSTOP = 2
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire thgs_pkg::thgs_hands_t hands_in,
    input wire logic guard_closed_in,
    input wire logic [N_PSTOP-1:0] pstop_ok_in,
    input wire logic [N_PSTOP-1:0] pstop_manual_in,
    input wire logic reset_switch_in,
    input wire logic pass_through_in,
    input wire logic [1:0] machine_stop_elements_out,
    input wire logic stop_cmd_out,
    input wire thgs_pkg::thgs_status_t status_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    sequence s_hand_off;
        !hands_in.left || !hands_in.right;
    endsequence
    sequence s_halted;
        machine_stop_elements_out == 2'h0;
    endsequence
    chk_release_stops: assert property (s_hand_off |-> ##[1:4] !status_out.run)
        else $error("run held after hand release");
    chk_run_both_hands: assert property ($rose(status_out.run)
        |-> $past(hands_in, 3) == 2'h3) else $error("run rose without both hands");
    chk_guard_halts: assert property (!guard_closed_in |-> ##[1:4] s_halted)
        else $error("open guard left actuators powered");
    chk_guard_stop_cmd: assert property ($fell(guard_closed_in) && status_out.run
        |-> ##[1:4] stop_cmd_out) else $error("no stop command on guard open");
    chk_close_no_start: assert property ($rose(guard_closed_in) && !status_out.run
        |-> !status_out.run [*4]) else $error("guard closing started motion");
    chk_pstop_halts: assert property (pstop_ok_in != {N_PSTOP{1'b1}}
        |-> ##[1:4] s_halted) else $error("protective stop left actuators powered");
    chk_pstop_stop_cmd: assert property ($fell(&pstop_ok_in) && status_out.run
        |-> ##[1:4] stop_cmd_out) else $error("no stop command on protective stop");
    chk_power_is_run: assert property (machine_stop_elements_out == {2{status_out.run}})
        else $error("actuator outputs differ from run");
    chk_expired_no_run: assert property (status_out.window_expired |-> !status_out.run)
        else $error("run while window expired");
    chk_latch_sets: assert property (!guard_closed_in && pass_through_in
        |-> ##[1:5] status_out.latched) else $error("stop not latched");
    chk_latch_holds: assert property ($fell(status_out.latched)
        && $past(pass_through_in, 3) |-> $past(reset_switch_in, 2)
        || $past(reset_switch_in, 3) || $past(reset_switch_in, 4))
        else $error("latch cleared without reset switch");
endmodule
bind thgs_top thgs_assertions #(.N_PSTOP(N_PSTOP)) u_thgs_assertions (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .hands_in(hands_in),
    .guard_closed_in(guard_closed_in), .pstop_ok_in(pstop_ok_in),
    .pstop_manual_in(pstop_manual_in), .reset_switch_in(reset_switch_in),
    .pass_through_in(pass_through_in), .machine_stop_elements_out(machine_stop_elements_out),
    .stop_cmd_out(stop_cmd_out), .status_out(status_out)
);
`default_nettype wire

//--- sim/thgs_machine_model.sv
`default_nettype none
module thgs_machine_model (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [1:0] power_in,
    output logic [7:0] strokes_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic powered_reg;
    // machine control counts strokes itself for anti-repeat
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            powered_reg <= 1'h0;
            strokes_out <= 8'h00;
        end
        else
        begin
            powered_reg <= &power_in;
            if (&power_in && !powered_reg)
                strokes_out <= strokes_out + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned W = 20;
    logic sys_clk_in = 1'h0;
    logic arst_n_in = 1'h0;
    thgs_pkg::thgs_hands_t hands = 2'h0;
    logic guard = 1'h1;
    logic [1:0] ps_ok = 2'h3;
    logic [1:0] manual = 2'h1;
    logic rst_sw = 1'h0;
    logic pass = 1'h0;
    logic [1:0] mse;
    logic stop_cmd;
    thgs_pkg::thgs_status_t st;
    logic [7:0] strokes;
    int error_cnt = 0;
    int check_count = 0;
    always #20 sys_clk_in = ~sys_clk_in;
    thgs_top #(.N_PSTOP(2), .WINDOW_CYCLES(W)) u_thgs_top (
        .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .hands_in(hands),
        .guard_closed_in(guard), .pstop_ok_in(ps_ok), .pstop_manual_in(manual),
        .reset_switch_in(rst_sw), .pass_through_in(pass),
        .machine_stop_elements_out(mse), .stop_cmd_out(stop_cmd), .status_out(st)
    );
    thgs_machine_model u_thgs_machine_model (
        .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .power_in(mse),
        .strokes_out(strokes)
    );
    task step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task want(input logic e, input bit w);
        int i;
        for (i = 0; i < 8 && w && st.run !== e; i++)
            step(1);
        if (!w)
            step(8);
        chk(st.run, e);
        if (w && st.run !== e)
            stop_test;
    endtask
    task press(input logic [1:0] v);
        hands = v;
        if (v == 2'h0)
            step(6);
    endtask
    task pulse_rst;
        rst_sw = 1'h1;
        step(6);
        rst_sw = 1'h0;
        step(4);
    endtask
    task stop_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task t_reset;
        press(2'h3);
        want(1'h1, 1);
        arst_n_in = 1'h0;
        step(2);
        chk(mse, 2'h0);
        chk(st.latched, 1'h1);
        arst_n_in = 1'h1;
        step(8);
        chk(st.blocked, 1'h1);
        want(1'h0, 0);
        press(2'h0);
        pulse_rst;
        press(2'h3);
        want(1'h1, 1);
        press(2'h0);
    endtask
    task t_start;
        press(2'h3);
        want(1'h1, 1);
        chk(mse, 2'h3);
        press(2'h2);
        want(1'h0, 1);
        press(2'h0);
    endtask
    task t_window;
        press(2'h2);
        step(W - 5);
        press(2'h3);
        want(1'h1, 1);
        press(2'h0);
        press(2'h2);
        step(W + 5);
        press(2'h3);
        want(1'h0, 0);
        chk(st.blocked, 1'h1);
        chk(st.window_expired, 1'h1);
        press(2'h2);
        step(6);
        press(2'h3);
        want(1'h0, 0);
        press(2'h0);
        chk(st.window_expired, 1'h0);
        press(2'h3);
        want(1'h1, 1);
        press(2'h0);
    endtask
    task t_tie;
        press(2'h2);
        step(3);
        press(2'h3);
        want(1'h1, 1);
        press(2'h2);
        step(6);
        press(2'h3);
        want(1'h0, 0);
        press(2'h0);
    endtask
    task t_guard;
        int i;
        press(2'h3);
        want(1'h1, 1);
        guard = 1'h0;
        for (i = 0; i < 8 && stop_cmd !== 1'h1; i++)
            step(1);
        chk(stop_cmd, 1'h1);
        if (stop_cmd !== 1'h1)
            stop_test;
        want(1'h0, 1);
        guard = 1'h1;
        want(1'h0, 0);
        press(2'h0);
        press(2'h3);
        want(1'h1, 1);
        press(2'h0);
    endtask
    task t_latch;
        pass = 1'h1;
        step(6);
        pulse_rst;
        chk(st.latched, 1'h0);
        guard = 1'h0;
        step(2);
        guard = 1'h1;
        step(6);
        chk(st.latched, 1'h1);
        press(2'h3);
        want(1'h0, 0);
        press(2'h0);
        pulse_rst;
        chk(st.latched, 1'h0);
        press(2'h3);
        want(1'h1, 1);
        press(2'h0);
        pass = 1'h0;
        step(6);
    endtask
    task t_pstop;
        press(2'h3);
        want(1'h1, 1);
        ps_ok = 2'h1;
        want(1'h0, 1);
        ps_ok = 2'h3;
        press(2'h0);
        press(2'h3);
        want(1'h1, 1);
        press(2'h0);
        ps_ok = 2'h2;
        step(4);
        ps_ok = 2'h3;
        step(6);
        press(2'h3);
        want(1'h0, 0);
        press(2'h0);
        pulse_rst;
        press(2'h3);
        want(1'h1, 1);
        press(2'h0);
    endtask
    initial
    begin
        step(10);
        arst_n_in = 1'h1;
        step(4);
        pulse_rst;
        t_reset;
        t_start;
        t_window;
        t_tie;
        t_guard;
        t_latch;
        t_pstop;
        chk(strokes, 8'h0b);
        stop_test;
    end
endmodule
`default_nettype wire
